//--- common/tec_crc_if.sv
`timescale 1ns/1ps
interface tec_crc_if;
  logic        start;  // first dword of a packet, restart from the seed
  logic        step;   // fold data into the running value this cycle
  logic [31:0] data;
  logic [31:0] value;  // finished digest over everything folded so far

  modport user   (output start, output step, output data, input value);
  modport engine (input start, input step, input data, output value);
endinterface

//--- common/tec_pkg.sv
package tec_pkg;
  // ****************************************************************
  // widths and register map
  // ****************************************************************
  localparam int          DATA_W       = 32;
  localparam int          REG_AW       = 8;
  localparam logic [7:0]  CTRL_OFF     = 8'h00;  // check, generate and forward enables
  localparam logic [7:0]  STATUS_OFF   = 8'h04;  // sticky events, write one to clear
  localparam logic [7:0]  MASK_OFF     = 8'h08;  // interrupt enables, status layout
  localparam logic [7:0]  ERRCNT_OFF   = 8'h0c;  // count of bad-digest packets dropped while checking
  localparam logic [7:0]  CAPS_OFF     = 8'h10;  // digest function built in

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int          CTRL_CHK_BIT = 0;
  localparam int          CTRL_GEN_BIT = 1;
  localparam int          CTRL_FWD_BIT = 2;
  localparam int          STS_ERR_BIT  = 0;
  localparam int          STS_OVF_BIT  = 1;
  localparam logic [2:0]  CTRL_RST     = 3'h0;
  localparam logic [1:0]  STATUS_RST   = 2'h0;
  localparam logic [1:0]  MASK_RST     = 2'h0;
  localparam logic [15:0] ERRCNT_RST   = 16'h0000;
  // ****************************************************************
  // packet header bits and digest polynomial
  // ****************************************************************
  localparam int          DIGEST_BIT   = 15;  // digest_present_bit of header dword 0
  localparam int          POISON_BIT   = 14;
  localparam int          TYPE0_BIT    = 24;
  localparam logic [31:0] CRC_INIT     = 32'hffffffff;
  localparam logic [31:0] CRC_POLY     = 32'hedb88320;

  // ****************************************************************
  // bus answers and register selectors
  // ****************************************************************
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

  typedef enum logic [2:0] {
    SEL_CTRL   = 3'h0,
    SEL_STATUS = 3'h1,
    SEL_MASK   = 3'h2,
    SEL_ERRCNT = 3'h3,
    SEL_CAPS   = 3'h4,
    SEL_NONE   = 3'h7
  } tec_sel_t;

  typedef enum logic [1:0] {
    RX_FILL    = 2'b00,
    RX_DRAIN   = 2'b01,
    RX_DISCARD = 2'b11
  } tec_rx_state_t;

  // variant header bits count as one in the digest, so hops may change them
  function automatic logic [31:0] crcCover(input logic [31:0] w, input logic hdr);
    logic [31:0] r;
    r = w;
    if (hdr)
    begin
      r[TYPE0_BIT]  = 1'b1;
      r[POISON_BIT] = 1'b1;
    end
    return r;
  endfunction

  // byte address to register selector
  function automatic tec_sel_t regSel(input logic [REG_AW-1:0] a);
    logic [REG_AW-1:0] w;
    w = {a[REG_AW-1:2], 2'b00};
    if (w == CTRL_OFF)
      return SEL_CTRL;
    else if (w == STATUS_OFF)
      return SEL_STATUS;
    else if (w == MASK_OFF)
      return SEL_MASK;
    else if (w == ERRCNT_OFF)
      return SEL_ERRCNT;
    else if (w == CAPS_OFF)
      return SEL_CAPS;
    return SEL_NONE;
  endfunction

endpackage

//--- rtl/tec_crc32.sv
`timescale 1ns/1ps
module tec_crc32 (
  // clock and reset
  input  wire logic core_clk,
  input  wire logic rst_n,
  // digest channel
  tec_crc_if.engine crc
);

  logic [31:0] crc_q;
  logic [31:0] crc_d;

  // byte 0 of the dword goes first, each byte least significant bit first
  function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [31:0] w);
    logic [31:0] r;
    logic        fb;
    r = c;
    for (int i = 0; i < 32; i++)
    begin
      fb = r[0] ^ w[24 - 8 * (i / 8) + (i % 8)];
      r  = {1'b0, r[31:1]} ^ (fb ? tec_pkg::CRC_POLY : 32'h00000000);
    end
    return r;
  endfunction

  // ****************************************************************
  // running value
  // ****************************************************************
  always_comb
  begin
    crc_d = crc_q;
    if (crc.step)
      crc_d = crcStep(crc.start ? tec_pkg::CRC_INIT : crc_q, crc.data);
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      crc_q <= tec_pkg::CRC_INIT;
    else
      crc_q <= crc_d;
  end

  // complemented, low byte of the register placed in byte 0 of the dword
  assign crc.value = {~crc_q[7:0], ~crc_q[15:8], ~crc_q[23:16], ~crc_q[31:24]};

endmodule // tec_crc32

//--- rtl/tec_handler.sv
// Contract
// - checking on: bad-digest packet raises error and is never delivered
// - checking off: no digest error, good or bad packets delivered
// - forwarding on: delivered packet keeps its digest dword
// - forwarding off: digest dword removed before delivery
// - packets without digest delivered unchanged, never flagged
// - generate on, forward off: digest appended, digest_present_bit forced one
// - both off: digest_present_bit cleared, nothing appended
// - forward on: transmit packet passed exactly as supplied
// - check and generate enables come from the control register
// - digest function exists only when all four build options set
//
// Implementation choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module tec_handler #(
  parameter int RX_DEPTH   = 64,    // dwords of the longest received packet
  parameter bit HAS_AER    = 1'b1,
  parameter bit HAS_CHECK  = 1'b1,
  parameter bit HAS_GEN    = 1'b1,
  parameter bit HAS_FWD    = 1'b1
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  // register bus, AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // received packets from the link
  input  wire logic [31:0] rxLinkData,
  input  wire logic        rxLinkSop,
  input  wire logic        rxLinkEop,
  input  wire logic        rxLinkValid,
  output logic             rxLinkReady,
  // received packets to the application
  output logic [31:0]      rxAppData,
  output logic             rxAppSop,
  output logic             rxAppEop,
  output logic             rxAppValid,
  input  wire logic        rxAppReady,
  output logic             rxEcrcErr,
  // transmit packets from the application
  input  wire logic [31:0] txAppData,
  input  wire logic        txAppSop,
  input  wire logic        txAppEop,
  input  wire logic        txAppValid,
  output logic             txAppReady,
  // transmit packets to the link
  output logic [31:0]      txLinkData,
  output logic             txLinkSop,
  output logic             txLinkEop,
  output logic             txLinkValid,
  input  wire logic        txLinkReady,
  // interrupt
  output logic             irq
);

  localparam int PTR_W = $clog2(RX_DEPTH);
  localparam bit PRESENT = HAS_AER && HAS_CHECK && HAS_GEN && HAS_FWD;

  if (RX_DEPTH < 8 || (1 << PTR_W) != RX_DEPTH)
  begin : g_bad_depth
    $error("RX_DEPTH must be a power of two of at least 8");
  end

  // ****************************************************************
  // control and status registers
  // ****************************************************************
  logic [2:0]            ctrl_q, ctrl_d;
  logic [1:0]            status_q, status_d;
  logic [1:0]            mask_q, mask_d;
  logic [15:0]           errCnt_q, errCnt_d;
  logic                  bvalid_q, bvalid_d;
  logic [1:0]            bresp_q, bresp_d;
  logic                  rvalid_q, rvalid_d;
  logic [1:0]            rresp_q, rresp_d;
  logic [31:0]           rdata_q, rdata_d;
  logic                  wrTake;
  logic                  rdTake;
  tec_pkg::tec_sel_t     wSel, rSel;
  logic                  errEvent, ovfEvent;
  logic                  chkOn, genOn, fwdOn;

  // effective modes; without the full build the block is a plain wire
  assign chkOn = PRESENT && ctrl_q[tec_pkg::CTRL_CHK_BIT];
  assign genOn = PRESENT && ctrl_q[tec_pkg::CTRL_GEN_BIT];
  assign fwdOn = !PRESENT || ctrl_q[tec_pkg::CTRL_FWD_BIT];

  // both write channels are taken together once the last answer is gone
  assign wrTake        = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
  assign s_axi_awready = wrTake;
  assign s_axi_wready  = wrTake;
  assign rdTake        = s_axi_arvalid && !rvalid_q;
  assign s_axi_arready = rdTake;
  assign wSel          = tec_pkg::regSel(s_axi_awaddr);
  assign rSel          = tec_pkg::regSel(s_axi_araddr);

  // register next values; a new event beats a clear in the same cycle
  always_comb
  begin
    ctrl_d   = ctrl_q;
    mask_d   = mask_q;
    status_d = status_q;
    errCnt_d = errCnt_q + {15'h0000, errEvent};
    bvalid_d = bvalid_q && !s_axi_bready;
    bresp_d  = bresp_q;
    rvalid_d = rvalid_q && !s_axi_rready;
    rresp_d  = rresp_q;
    rdata_d  = rdata_q;
    if (wrTake)
    begin
      bvalid_d = 1'b1;
      bresp_d  = (wSel == tec_pkg::SEL_NONE) ? tec_pkg::RESP_SLVERR : tec_pkg::RESP_OKAY;
      if (s_axi_wstrb[0])
      begin
        if (wSel == tec_pkg::SEL_CTRL)
          ctrl_d = s_axi_wdata[2:0];
        if (wSel == tec_pkg::SEL_MASK)
          mask_d = s_axi_wdata[1:0];
        if (wSel == tec_pkg::SEL_STATUS)
          status_d = status_q & ~s_axi_wdata[1:0];
      end
    end
    status_d[tec_pkg::STS_ERR_BIT] = status_d[tec_pkg::STS_ERR_BIT] | errEvent;
    status_d[tec_pkg::STS_OVF_BIT] = status_d[tec_pkg::STS_OVF_BIT] | ovfEvent;
    if (rdTake)
    begin
      rvalid_d = 1'b1;
      rresp_d  = tec_pkg::RESP_OKAY;
      unique case (rSel)
        tec_pkg::SEL_CTRL:   rdata_d = {29'h00000000, ctrl_q};
        tec_pkg::SEL_STATUS: rdata_d = {30'h00000000, status_q};
        tec_pkg::SEL_MASK:   rdata_d = {30'h00000000, mask_q};
        tec_pkg::SEL_ERRCNT: rdata_d = {16'h0000, errCnt_q};
        tec_pkg::SEL_CAPS:   rdata_d = {31'h00000000, PRESENT};
        default:
        begin
          rdata_d = 32'h00000000;
          rresp_d = tec_pkg::RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_q   <= tec_pkg::CTRL_RST;
      status_q <= tec_pkg::STATUS_RST;
      mask_q   <= tec_pkg::MASK_RST;
      errCnt_q <= tec_pkg::ERRCNT_RST;
      bvalid_q <= 1'b0;
      bresp_q  <= tec_pkg::RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= tec_pkg::RESP_OKAY;
      rdata_q  <= 32'h00000000;
    end
    else
    begin
      ctrl_q   <= ctrl_d;
      status_q <= status_d;
      mask_q   <= mask_d;
      errCnt_q <= errCnt_d;
      bvalid_q <= bvalid_d;
      bresp_q  <= bresp_d;
      rvalid_q <= rvalid_d;
      rresp_q  <= rresp_d;
      rdata_q  <= rdata_d;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp  = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp  = rresp_q;
  assign s_axi_rdata  = rdata_q;
  assign irq          = |(status_q & mask_q);

  // ****************************************************************
  // receive path, store and forward
  // ****************************************************************
  // a whole packet is held so a bad digest can still withhold it
  logic [31:0]           rxMem [RX_DEPTH];
  tec_pkg::tec_rx_state_t rxState_q, rxState_d;
  logic [PTR_W-1:0]      wrPtr_q, wrPtr_d;
  logic [PTR_W-1:0]      rdPtr_q, rdPtr_d;
  logic [PTR_W-1:0]      lastIdx_q, lastIdx_d;
  logic [31:0]           rxOut_q, rxOut_d;
  logic                  rxDigest_q, rxDigest_d;
  logic                  rxErr_q;
  logic                  rxBeat, rxDig, rxBad, rxStrip;
  logic [PTR_W-1:0]      wIdx;
  logic [31:0]           rxFirst;
  tec_crc_if             rxCrc ();

  assign rxLinkReady = (rxState_q != tec_pkg::RX_DRAIN);
  assign rxBeat      = rxLinkValid && rxLinkReady;
  assign wIdx        = rxLinkSop ? '0 : wrPtr_q;
  assign rxDig       = rxLinkSop ? rxLinkData[tec_pkg::DIGEST_BIT] : rxDigest_q;
  assign rxBad       = rxDig && (rxCrc.value != rxLinkData);
  assign rxStrip     = rxDig && !fwdOn && (wIdx != '0);
  assign rxFirst     = (wIdx == '0) ? rxLinkData : rxMem[0];

  // the digest dword itself is compared, not folded in
  assign rxCrc.start = rxLinkSop;
  assign rxCrc.step  = rxBeat && (rxState_q == tec_pkg::RX_FILL) && !(rxLinkEop && rxDig);
  assign rxCrc.data  = tec_pkg::crcCover(rxLinkData, rxLinkSop);

  always_comb
  begin
    rxState_d  = rxState_q;
    wrPtr_d    = wrPtr_q;
    rdPtr_d    = rdPtr_q;
    lastIdx_d  = lastIdx_q;
    rxOut_d    = rxOut_q;
    rxDigest_d = rxDig;
    errEvent   = 1'b0;
    ovfEvent   = 1'b0;
    unique case (rxState_q)
      tec_pkg::RX_FILL:
        if (rxBeat)
        begin
          if (rxLinkEop)
          begin
            wrPtr_d = '0;
            if (chkOn && rxBad)
              errEvent = 1'b1;  // drop and report
            else
            begin
              // everything else goes out, digest kept in forward mode
              rxState_d = tec_pkg::RX_DRAIN;
              rdPtr_d   = '0;
              lastIdx_d = rxStrip ? wIdx - 1'b1 : wIdx;
              rxOut_d   = rxFirst;
              if (rxStrip)
                rxOut_d[tec_pkg::DIGEST_BIT] = 1'b0;  // header now says no digest
            end
          end
          else if (wIdx == PTR_W'(RX_DEPTH - 1))
          begin
            ovfEvent  = 1'b1;  // too long to hold, the whole packet is thrown away
            rxState_d = tec_pkg::RX_DISCARD;
          end
          else
            wrPtr_d = wIdx + 1'b1;
        end
      tec_pkg::RX_DRAIN:
        if (rxAppReady)
        begin
          if (rdPtr_q == lastIdx_q)
            rxState_d = tec_pkg::RX_FILL;
          else
          begin
            rdPtr_d = rdPtr_q + 1'b1;
            rxOut_d = rxMem[rdPtr_q + 1'b1];
          end
        end
      tec_pkg::RX_DISCARD:
        if (rxBeat && rxLinkEop)
        begin
          rxState_d = tec_pkg::RX_FILL;
          wrPtr_d   = '0;
        end
      default:
        rxState_d = tec_pkg::RX_FILL;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rxState_q  <= tec_pkg::RX_FILL;
      wrPtr_q    <= '0;
      rdPtr_q    <= '0;
      lastIdx_q  <= '0;
      rxOut_q    <= 32'h00000000;
      rxDigest_q <= 1'b0;
      rxErr_q    <= 1'b0;
    end
    else
    begin
      rxState_q  <= rxState_d;
      wrPtr_q    <= wrPtr_d;
      rdPtr_q    <= rdPtr_d;
      lastIdx_q  <= lastIdx_d;
      rxOut_q    <= rxOut_d;
      rxDigest_q <= rxDigest_d;
      rxErr_q    <= errEvent;
    end
  end

  // packet store, no reset needed for data words
  always_ff @(posedge core_clk)
  begin
    if (rxBeat && rxState_q == tec_pkg::RX_FILL)
      rxMem[wIdx] <= rxLinkData;
  end

  assign rxAppValid = (rxState_q == tec_pkg::RX_DRAIN);
  assign rxAppData  = rxOut_q;
  assign rxAppSop   = (rdPtr_q == '0);
  assign rxAppEop   = (rdPtr_q == lastIdx_q);
  assign rxEcrcErr  = rxErr_q;

  tec_crc32 u_rx_crc (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .crc      (rxCrc.engine)
  );

  // ****************************************************************
  // transmit path, one output stage plus digest insertion
  // ****************************************************************
  logic [31:0]           txData_q, txData_d;
  logic                  txSop_q, txSop_d;
  logic                  txEop_q, txEop_d;
  logic                  txValid_q, txValid_d;
  logic                  txPend_q, txPend_d;
  logic                  txGen_q, txGen_d;
  logic                  txFree, txBeat, genPkt;
  logic [31:0]           txWord;
  tec_crc_if             txCrc ();

  assign txFree     = !txValid_q || txLinkReady;
  assign txAppReady = txFree && !txPend_q;  // stalls while the digest goes out
  assign txBeat     = txAppValid && txAppReady;
  assign genPkt     = txAppSop ? (genOn && !fwdOn) : txGen_q;

  // header bit follows the mode unless forwarding
  always_comb
  begin
    txWord = txAppData;
    if (txAppSop && !fwdOn)
      txWord[tec_pkg::DIGEST_BIT] = genOn;
  end

  assign txCrc.start = txAppSop;
  assign txCrc.step  = txBeat && genPkt;
  assign txCrc.data  = tec_pkg::crcCover(txWord, txAppSop);

  always_comb
  begin
    txData_d  = txData_q;
    txSop_d   = txSop_q;
    txEop_d   = txEop_q;
    txValid_d = txValid_q && !txLinkReady;
    txPend_d  = txPend_q;
    txGen_d   = txBeat ? genPkt : txGen_q;
    if (txBeat)
    begin
      txValid_d = 1'b1;
      txData_d  = txWord;
      txSop_d   = txAppSop;
      txEop_d   = txAppEop && !genPkt;
      txPend_d  = txAppEop && genPkt;
    end
    else if (txPend_q && txFree)
    begin
      txValid_d = 1'b1;
      txData_d  = txCrc.value;  // appended digest closes the packet
      txSop_d   = 1'b0;
      txEop_d   = 1'b1;
      txPend_d  = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      txData_q  <= 32'h00000000;
      txSop_q   <= 1'b0;
      txEop_q   <= 1'b0;
      txValid_q <= 1'b0;
      txPend_q  <= 1'b0;
      txGen_q   <= 1'b0;
    end
    else
    begin
      txData_q  <= txData_d;
      txSop_q   <= txSop_d;
      txEop_q   <= txEop_d;
      txValid_q <= txValid_d;
      txPend_q  <= txPend_d;
      txGen_q   <= txGen_d;
    end
  end

  assign txLinkData  = txData_q;
  assign txLinkSop   = txSop_q;
  assign txLinkEop   = txEop_q;
  assign txLinkValid = txValid_q;

  tec_crc32 u_tx_crc (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .crc      (txCrc.engine)
  );

endmodule // tec_handler

//--- sim/tec_app_model.sv
`timescale 1ns/1ps
module tec_app_model (
  // clock, reset and pacing
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic appSlow,
  // received packets
  output logic     rxAppReady,
  // transmit packets
  output logic [31:0] txAppData,
  output logic     txAppSop,
  output logic     txAppEop,
  output logic     txAppValid,
  input wire logic txAppReady
);
  // slow mode takes every other beat so the design must hold its output
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
      rxAppReady <= 1'b0;
    else
      rxAppReady <= !appSlow || !rxAppReady;

  initial {txAppData, txAppSop, txAppEop, txAppValid} = '0;

  // caller builds the digest itself when forwarding listed combinations only
  task automatic send(input logic [31:0] d[$]);
    foreach (d[i])
    begin
      txAppData <= d[i];
      txAppSop <= i == 0;
      txAppEop <= i == d.size() - 1;
      txAppValid <= 1'b1;
      do @(posedge core_clk); while (txAppReady !== 1'b1);
    end
    txAppValid <= 1'b0;
    txAppData <= ~d[d.size() - 1];  // released data never shows the last beat
  endtask
endmodule // tec_app_model

//--- sim/tec_handler_monitor.sv
`timescale 1ns/1ps
module tec_handler_monitor (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst_n,
  // register writes and interrupt
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_bvalid,
  input wire logic        irq,
  // packet streams
  input wire logic [31:0] rxAppData,
  input wire logic        rxAppSop,
  input wire logic        rxAppValid,
  input wire logic        rxAppReady,
  input wire logic        rxEcrcErr,
  input wire logic [31:0] txAppData,
  input wire logic        txAppValid,
  input wire logic        txAppReady,
  input wire logic [31:0] txLinkData,
  input wire logic        txLinkSop,
  input wire logic        txLinkValid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] ctl_q;
  logic       msk_q;

  // mirror of control and mask, so mode checks need no design internals
  always_ff @(posedge core_clk or negedge rst_n)
    if (!rst_n)
    begin
      ctl_q <= 3'h0;
      msk_q <= 1'b0;
    end
    else if (s_axi_awvalid && s_axi_wvalid && s_axi_awready && s_axi_wstrb[0])
    begin
      if (s_axi_awaddr == tec_pkg::CTRL_OFF) ctl_q <= s_axi_wdata[2:0];
      if (s_axi_awaddr == tec_pkg::MASK_OFF) msk_q <= s_axi_wdata[0];
    end

  chk_err_pulse: assert property (rxEcrcErr |=> !rxEcrcErr)
    else $error("drop flag longer than one cycle");
  chk_err_drop: assert property (rxEcrcErr |-> !rxAppValid)
    else $error("dropped packet shown to application");
  chk_err_gated: assert property (rxEcrcErr |-> ctl_q[0])
    else $error("digest error while checking off");
  chk_rx_hold: assert property (rxAppValid && !rxAppReady |=> rxAppValid && $stable(rxAppData))
    else $error("receive beat changed while stalled");
  chk_rx_strip: assert property (rxAppValid && rxAppSop && !ctl_q[2] |-> !rxAppData[15])
    else $error("digest bit left set without forwarding");
  chk_tx_gen: assert property (txLinkValid && txLinkSop && ctl_q[2:1] == 2'h1 |-> txLinkData[15])
    else $error("digest bit not forced on");
  chk_tx_off: assert property (txLinkValid && txLinkSop && ctl_q[2:1] == 2'h0 |-> !txLinkData[15])
    else $error("digest bit not cleared");
  chk_tx_pass: assert property (txAppValid && txAppReady && ctl_q[2]
    |=> txLinkValid && txLinkData == $past(txAppData))
    else $error("forwarded dword altered");
  chk_irq_mask: assert property ($rose(irq) |-> msk_q)
    else $error("interrupt raised while masked");
  chk_bus_resp: assert property (s_axi_awvalid && s_axi_wvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");

  cover property (rxEcrcErr);
  cover property (txLinkValid && ctl_q[2:1] == 2'h1 && !txLinkSop);
  cover property ($rose(irq));
endmodule // tec_handler_monitor

bind tec_handler tec_handler_monitor u_mon (.*);

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  // **********
  // signals and instances
  // **********
  logic        core_clk, rst_n, appSlow, irq, rxEcrcErr;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [31:0] s_axi_wdata, s_axi_rdata, rxLinkData, rxAppData, txAppData, txLinkData, v, h;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        rxLinkSop, rxLinkEop, rxLinkValid, rxLinkReady, rxAppSop, rxAppEop;
  logic        rxAppValid, rxAppReady, txAppSop, txAppEop, txAppValid, txAppReady;
  logic        txLinkSop, txLinkEop, txLinkValid, txLinkReady;
  logic [31:0] rxGot[$], txGot[$], pk[$], ex[$];
  int          n_checks, n_mismatch, nErr, k;
  // rows: forward, check, digest kind (0 none, 1 good, 2 bad), error expected
  localparam logic [4:0] ROWS[12] = '{5'h00, 5'h02, 5'h04, 5'h08, 5'h0a, 5'h0d,
                                      5'h10, 5'h12, 5'h14, 5'h18, 5'h1a, 5'h1d};
  tec_handler uut (.*);
  tec_app_model app (.*);

  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // capture both streams; link side stalls every other cycle
  always @(posedge core_clk)
  begin
    if (rxAppValid && rxAppReady) rxGot.push_back(rxAppData ^ 32'(rxAppEop));
    if (txLinkValid && txLinkReady) txGot.push_back(txLinkData ^ 32'(txLinkEop));
    if (rxEcrcErr === 1'b1) nErr++;
    txLinkReady <= ~txLinkReady;
  end

  // hang guard, far above the few hundred cycles the run needs
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    test_done;
  end

  // **********
  // tasks
  // **********
  task chk(input logic [31:0] g[$], input logic [31:0] e[$]);
    bit bad;
    bad = g.size() != e.size();
    foreach (e[i]) if (i < g.size() && g[i] !== e[i]) bad = 1;
    n_checks++;
    if (bad)
    begin
      n_mismatch++;
      $display("BAD %0t: got %p want %p", $time, g, e);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge core_clk); while (s_axi_awready !== 1'b1);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    while (s_axi_bvalid !== 1'b1) @(posedge core_clk);
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge core_clk);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task rxSend(input logic [31:0] d[$]);
    foreach (d[i])
    begin
      rxLinkData <= d[i];
      rxLinkSop <= i == 0;
      rxLinkEop <= i == d.size() - 1;
      rxLinkValid <= 1'b1;
      do @(posedge core_clk); while (rxLinkReady !== 1'b1);
    end
    rxLinkValid <= 1'b0;
    rxLinkData <= ~d[d.size() - 1];
  endtask

  // reflected crc, byte0 first and lsb first, header variant bits as one
  function automatic logic [31:0] crc(input logic [31:0] d[$]);
    logic [31:0] c, w;
    c = 32'hffffffff;
    foreach (d[i])
    begin
      w = d[i] | (i == 0 ? 32'h01004000 : 32'h0);
      for (int b = 0; b < 32; b++)
        c = (c >> 1) ^ ((c[0] ^ w[(3 - b / 8) * 8 + b % 8]) ? tec_pkg::CRC_POLY : 32'h0);
    end
    c = ~c;
    return {c[7:0], c[15:8], c[23:16], c[31:24]};
  endfunction

  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // **********
  // main sequence
  // **********
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready, rxLinkData, rxLinkSop} = '0;
    {rxLinkEop, rxLinkValid, txLinkReady, appSlow, rst_n} = '0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    // reset values, capability word, then the unmapped word after it
    for (k = 0; k < 6; k++)
    begin
      rd(8'(k * 4));
      chk('{v, 32'(rs)}, '{32'(k == 4), 32'(k == 5 ? 2 : 0)});
    end
    foreach (ROWS[r])
    begin
      appSlow <= 1'(r % 2);
      wr(tec_pkg::CTRL_OFF, {29'h0, ROWS[r][4], 1'b0, ROWS[r][3]});
      h = {16'h4000, ROWS[r][2:1] != 2'h0, 15'h1};
      pk = '{h, 32'hc0de0000 + 32'(r)};
      if (ROWS[r][2:1] != 2'h0) pk.push_back(crc(pk) ^ {32{ROWS[r][2]}});
      ex = pk;
      if (ROWS[r][0]) ex = {};
      else if (!ROWS[r][4] && ROWS[r][2:1] != 2'h0)
      begin
        void'(ex.pop_back());
        ex[0][15] = 1'b0;
      end
      if (ex.size() > 0) ex[$] ^= 32'h1;
      rxGot = {};
      nErr = 0;
      rxSend(pk);
      for (k = 0; k < 60 && !(rxGot.size() == ex.size() && nErr == ROWS[r][0]); k++)
        @(posedge core_clk);
      chk(rxGot, ex);
      chk('{nErr}, '{ROWS[r][0]});
    end
    // sticky status held back by the mask, then raised and cleared
    rd(tec_pkg::ERRCNT_OFF);
    chk('{v}, '{32'h2});
    rd(tec_pkg::STATUS_OFF);
    chk('{v, 32'(irq)}, '{32'h1, 32'h0});
    wr(tec_pkg::MASK_OFF, 32'h1);
    chk('{32'(irq)}, '{32'h1});
    wr(tec_pkg::STATUS_OFF, 32'h1);
    chk('{32'(irq)}, '{32'h0});
    // every generate and forward mode, with the application bit low and high
    for (int m = 0; m < 8; m++)
    begin
      wr(tec_pkg::CTRL_OFF, {29'h0, m[1], m[0], 1'b0});
      pk = '{{16'h4000, m[2], 15'h1}, 32'h5a5a0000 + 32'(m)};
      if (m[1] && m[2]) pk.push_back(crc(pk));
      ex = pk;
      if (!m[1])
      begin
        ex[0][15] = m[0];
        if (m[0]) ex.push_back(crc(ex));
      end
      ex[$] ^= 32'h1;
      txGot = {};
      app.send(pk);
      for (k = 0; k < 60 && txGot.size() < ex.size(); k++) @(posedge core_clk);
      chk(txGot, ex);
    end
    test_done;
  end
endmodule // testbench
